// *** design/pbw_pkg.sv ***
/*
  Package for the PID boost output and link watchdog block: register offsets,
  field positions, reset values, response encodings and timing constants.
  Assumes a single 10 MHz system clock and a simple strobe register port.
*/
package pbw_pkg;
    localparam int PBW_ADDR_W = 4;
    localparam int PBW_PV_W = 16;
    localparam int PBW_TMO_W = 16;
    localparam int PBW_CLK_HZ = 10000000;
    localparam int PBW_TICK_US = 1000;
    localparam int PBW_TICK_CYC = PBW_CLK_HZ / 1000000 * PBW_TICK_US;

    localparam logic [3:0] PBW_OFS_PVLO = 4'h0;
    localparam logic [3:0] PBW_OFS_PVHI = 4'h4;
    localparam logic [3:0] PBW_OFS_TMO = 4'h8;
    localparam logic [3:0] PBW_OFS_CTRL = 4'hC;
    localparam logic [3:0] PBW_OFS_STAT = 4'h1;
    localparam logic [3:0] PBW_OFS_IRQST = 4'h2;
    localparam logic [3:0] PBW_OFS_IRQMSK = 4'h3;

    localparam logic [15:0] PBW_PVLO_RST = 16'h0000;
    localparam logic [15:0] PBW_PVHI_RST = 16'h0000;
    localparam logic [15:0] PBW_TMO_RST = 16'h0000;
    localparam logic [1:0] PBW_CTRL_RST = 2'h0;

    localparam int PBW_CTRL_RESP_LSB = 0;
    localparam int PBW_STAT_RUN = 0;
    localparam int PBW_STAT_BOOST = 1;
    localparam int PBW_STAT_TMO = 2;
    localparam int PBW_STAT_TRIP = 3;
    localparam int PBW_IRQ_BOOSTON = 0;
    localparam int PBW_IRQ_BOOSTOFF = 1;
    localparam int PBW_IRQ_TMO = 2;
    localparam int PBW_IRQ_W = 3;

    typedef enum logic [1:0] {
        PBW_RESP_TRIP_DECEL = 2'h0,
        PBW_RESP_DECEL = 2'h1,
        PBW_RESP_IGNORE = 2'h2,
        PBW_RESP_COAST = 2'h3
    } pbw_resp_t;
endpackage

// *** design/pbw_top.sv ***
/*
  PID second-stage boost output and link watchdog with register port.
  Assumes all inputs are synchronous to sys_clk; pv and the limits share the
  setpoint percentage scale; the frame strobe marks one valid received frame.
*/
// The implementer's own choices: the plain strobed port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
// Contract
// - Forward run command high enters run; low keeps stop. The code also keeps stop while a trip is latched.
// - In run, boost sets when process value is below low limit.
// - Boost clears when process value exceeds high limit.
// - Between limits the boost holds its previous state.
// - Leaving run clears boost regardless of process value.
// - Process value and limits compare in setpoint percentage units.
// - Timeout output asserts when traffic pauses beyond the timeout period.
// - On timeout, act per error response: trip, decelerate or coast.
module pbw_top
    import pbw_pkg::*;
#(
    parameter int TICK_CYC = PBW_TICK_CYC
) (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic forward_run_command,
    input wire logic [PBW_PV_W-1:0] pvPercent,
    input wire logic frameValid,
    input wire logic tripClear,
    input wire logic [PBW_ADDR_W-1:0] regAddr,
    input wire logic [15:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    output logic [15:0] regRdata,
    output logic pid_boost_output,
    output logic network_timeout_output,
    output logic tripE60,
    output logic decelStop,
    output logic coastStop,
    output logic irq
);
    logic [PBW_PV_W-1:0] pv_low_limit_q;
    logic [PBW_PV_W-1:0] pv_high_limit_q;
    logic [PBW_TMO_W-1:0] comm_timeout_period_q;
    pbw_resp_t comm_error_response_q;
    logic runMode_q;
    logic boost_q;
    logic trip_q;
    logic timedOut;
    logic timedOutPrev_q;
    logic tmoEvent;
    logic boostPrev_q;
    logic [PBW_IRQ_W-1:0] irqStat_q;
    logic [PBW_IRQ_W-1:0] irqMask_q;
    logic [PBW_IRQ_W-1:0] irqEvents;
    logic [15:0] rdata_q;

    function automatic logic wrHit(input logic [3:0] ofs);
        wrHit = regWr && (regAddr == ofs);
    endfunction

    pbw_watchdog #(
        .TICK_CYC(TICK_CYC)
    ) u_wd (
        .sys_clk(sys_clk),
        .reset(reset),
        .frameValid(frameValid),
        .commTimeoutPeriod(comm_timeout_period_q),
        .timedOut(timedOut)
    );

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            pv_low_limit_q <= PBW_PVLO_RST;
            pv_high_limit_q <= PBW_PVHI_RST;
            comm_timeout_period_q <= PBW_TMO_RST;
            comm_error_response_q <= pbw_resp_t'(PBW_CTRL_RST);
        end else begin
            if (wrHit(PBW_OFS_PVLO)) begin
                pv_low_limit_q <= regWdata;
            end
            if (wrHit(PBW_OFS_PVHI)) begin
                pv_high_limit_q <= regWdata;
            end
            if (wrHit(PBW_OFS_TMO)) begin
                comm_timeout_period_q <= regWdata;
            end
            if (wrHit(PBW_OFS_CTRL)) begin
                comm_error_response_q <= pbw_resp_t'(regWdata[PBW_CTRL_RESP_LSB +: 2]);
            end
        end
    end

    // A trip stops the drive too, so run needs both the command and no trip.
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            runMode_q <= 1'b0;
        end else begin
            runMode_q <= forward_run_command && !trip_q;
        end
    end

    // Same unsigned scale on both sides keeps the comparison in percent.
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            boost_q <= 1'b0;
        end else if (!runMode_q || !forward_run_command) begin
            boost_q <= 1'b0;
        end else if (pvPercent > pv_high_limit_q) begin
            boost_q <= 1'b0;
        end else if (pvPercent < pv_low_limit_q) begin
            boost_q <= 1'b1;
        end
    end

    // Boost drives the second stage run input directly.
    assign pid_boost_output = boost_q;
    assign network_timeout_output = timedOut;

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            timedOutPrev_q <= 1'b0;
            boostPrev_q <= 1'b0;
        end else begin
            timedOutPrev_q <= timedOut;
            boostPrev_q <= boost_q;
        end
    end

    assign tmoEvent = timedOut && !timedOutPrev_q;

    // The trip latches until cleared, even when traffic resumes.
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            trip_q <= 1'b0;
        end else if (tmoEvent && comm_error_response_q == PBW_RESP_TRIP_DECEL) begin
            trip_q <= 1'b1;
        end else if (tripClear) begin
            trip_q <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            tripE60 <= 1'b0;
            decelStop <= 1'b0;
            coastStop <= 1'b0;
        end else begin
            tripE60 <= trip_q;
            decelStop <= trip_q || (timedOut && comm_error_response_q == PBW_RESP_DECEL);
            coastStop <= timedOut && comm_error_response_q == PBW_RESP_COAST;
        end
    end

    assign irqEvents[PBW_IRQ_BOOSTON] = boost_q && !boostPrev_q;
    assign irqEvents[PBW_IRQ_BOOSTOFF] = !boost_q && boostPrev_q;
    assign irqEvents[PBW_IRQ_TMO] = tmoEvent;

    // Set wins over a simultaneous write-one clear so no event is lost.
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            irqStat_q <= '0;
            irqMask_q <= '0;
        end else begin
            if (wrHit(PBW_OFS_IRQST)) begin
                irqStat_q <= (irqStat_q & ~regWdata[PBW_IRQ_W-1:0]) | irqEvents;
            end else begin
                irqStat_q <= irqStat_q | irqEvents;
            end
            if (wrHit(PBW_OFS_IRQMSK)) begin
                irqMask_q <= regWdata[PBW_IRQ_W-1:0];
            end
        end
    end

    assign irq = |(irqStat_q & irqMask_q);

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            rdata_q <= 16'h0000;
        end else if (regRd) begin
            unique case (regAddr)
                PBW_OFS_PVLO: rdata_q <= pv_low_limit_q;
                PBW_OFS_PVHI: rdata_q <= pv_high_limit_q;
                PBW_OFS_TMO: rdata_q <= comm_timeout_period_q;
                PBW_OFS_CTRL: rdata_q <= {14'h0000, comm_error_response_q};
                PBW_OFS_STAT: rdata_q <= {12'h000, trip_q, timedOut, boost_q, runMode_q};
                PBW_OFS_IRQST: rdata_q <= {13'h0000, irqStat_q};
                PBW_OFS_IRQMSK: rdata_q <= {13'h0000, irqMask_q};
                default: rdata_q <= 16'h0000;
            endcase
        end else begin
            rdata_q <= 16'h0000;
        end
    end

    assign regRdata = rdata_q;
endmodule
`default_nettype wire

// *** design/pbw_watchdog.sv ***
/*
  Communication watchdog: counts millisecond ticks since the last valid frame.
  Assumes the frame strobe is a one-cycle pulse synchronous to sys_clk.
*/
`timescale 1ns/1ps
`default_nettype none
module pbw_watchdog
    import pbw_pkg::*;
#(
    parameter int TICK_CYC = PBW_TICK_CYC
) (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic frameValid,
    input wire logic [PBW_TMO_W-1:0] commTimeoutPeriod,
    output logic timedOut
);
    logic [15:0] tickCnt_q;
    logic [PBW_TMO_W-1:0] msCnt_q;
    logic tick;

    assign tick = (tickCnt_q == 16'(TICK_CYC - 1));

    always_ff @(posedge sys_clk) begin
        if (reset || frameValid) begin
            tickCnt_q <= 16'h0000;
        end else if (tick) begin
            tickCnt_q <= 16'h0000;
        end else begin
            tickCnt_q <= tickCnt_q + 16'h0001;
        end
    end

    // A zero period disables the watchdog, so a link never used cannot time out.
    always_ff @(posedge sys_clk) begin
        if (reset || frameValid) begin
            msCnt_q <= '0;
        end else if (tick && !timedOut) begin
            msCnt_q <= msCnt_q + 1'b1;
        end
    end

    assign timedOut = (commTimeoutPeriod != '0) && (msCnt_q > commTimeoutPeriod);
endmodule
`default_nettype wire

// *** dv/pbw_checker.sv ***
/*
  Port checker for pbw_top: boost thresholds, stop clearing and watchdog.
  Assumes it is bound into pbw_top and handed the same TICK_CYC.
*/
`timescale 1ns/1ps
`default_nettype none
module pbw_checker
    import pbw_pkg::*;
#(
    parameter int TICK_CYC = PBW_TICK_CYC
) (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic forward_run_command,
    input wire logic [PBW_PV_W-1:0] pvPercent,
    input wire logic frameValid,
    input wire logic [PBW_ADDR_W-1:0] regAddr,
    input wire logic [15:0] regWdata,
    input wire logic regWr,
    input wire logic pid_boost_output,
    input wire logic network_timeout_output,
    input wire logic tripE60,
    input wire logic decelStop,
    input wire logic coastStop
);
    logic [15:0] loLim_q, hiLim_q, period_q;
    logic [1:0] resp_q;
    logic [19:0] gap_q;
    // Shadow registers, since the checker cannot see inside the block.
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            loLim_q <= PBW_PVLO_RST;
            hiLim_q <= PBW_PVHI_RST;
            period_q <= PBW_TMO_RST;
            resp_q <= PBW_CTRL_RST;
        end else if (regWr) begin
            if (regAddr == PBW_OFS_PVLO) loLim_q <= regWdata;
            if (regAddr == PBW_OFS_PVHI) hiLim_q <= regWdata;
            if (regAddr == PBW_OFS_TMO) period_q <= regWdata;
            if (regAddr == PBW_OFS_CTRL) resp_q <= regWdata[1:0];
        end
    end
    always_ff @(posedge sys_clk) begin
        gap_q <= (reset || frameValid) ? 20'h00000 : gap_q + 20'h00001;
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);
    a_stop_clears: assert property (
        !forward_run_command |=> !pid_boost_output) else $error("boost left set in stop");
    a_boost_rise: assert property ($rose(pid_boost_output) |->
        $past(forward_run_command, 2) && $past(pvPercent) < $past(loLim_q)) else $error("bad boost set");
    a_boost_fall: assert property ($fell(pid_boost_output) |->
        !$past(forward_run_command) || $past(pvPercent) > $past(hiLim_q) || tripE60) else $error("bad boost clear");
    a_frame_clears: assert property (
        frameValid |=> !network_timeout_output) else $error("frame left timeout set");
    a_tmo_early: assert property (network_timeout_output |->
        period_q != 0 && gap_q >= period_q * TICK_CYC) else $error("timeout too early");
    a_tmo_late: assert property (period_q != 0 && gap_q > (period_q + 2) * TICK_CYC |->
        network_timeout_output) else $error("timeout missing");
    a_trip_resp: assert property ($rose(network_timeout_output) && resp_q == 2'h0 |->
        ##[1:2] tripE60) else $error("no trip");
    a_decel_resp: assert property ($rose(network_timeout_output) && resp_q == 2'h1 |->
        ##[1:2] decelStop) else $error("no decel");
    a_coast_resp: assert property ($rose(network_timeout_output) && resp_q == 2'h3 |->
        ##[1:2] coastStop) else $error("no coast");
endmodule
`default_nettype wire

// *** dv/pbw_stage2_model.sv ***
/*
  Second-stage drive: takes the boost output as its forward run command.
  Assumes that command is a level synchronous to sys_clk.
*/
`timescale 1ns/1ps
`default_nettype none
module pbw_stage2_model (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic runCmd,
    output logic running
);
    // A real drive ramps; one cycle of lag keeps the bench timing simple.
    always_ff @(posedge sys_clk) begin
        running <= reset ? 1'b0 : runCmd;
    end
endmodule
`default_nettype wire

// *** dv/test_pid_boost_and_link_watchdog.sv ***
/*
  Bench for pbw_top: register port, boost hysteresis, watchdog responses.
  Assumes TICK_CYC is shortened to 10 cycles per watchdog tick.
*/
`timescale 1ns/1ps
`default_nettype none
module test_pid_boost_and_link_watchdog
    import pbw_pkg::*;
;
    logic sys_clk = 1'b0, reset = 1'b1, fwd = 1'b0, frameValid = 1'b0, tripClear = 1'b0;
    logic regWr = 1'b0, regRd = 1'b0, rdLag = 1'b0, boost, tmo, trip, decel, coast, irq, running;
    logic [15:0] pv = 16'h0000, regWdata = 16'h0000, regRdata;
    logic [3:0] regAddr = 4'h0;
    logic [15:0] expQ[$];
    int n_mismatch = 0, total_checks = 0, cycles = 0;
    pbw_top #(.TICK_CYC(10)) dut_u (.sys_clk(sys_clk), .reset(reset), .forward_run_command(fwd),
        .pvPercent(pv), .frameValid(frameValid), .tripClear(tripClear), .regAddr(regAddr),
        .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .pid_boost_output(boost),
        .network_timeout_output(tmo), .tripE60(trip), .decelStop(decel), .coastStop(coast), .irq(irq));
    pbw_stage2_model stage2U (.sys_clk(sys_clk), .reset(reset), .runCmd(boost), .running(running));
    initial begin
        forever #50 sys_clk = ~sys_clk;
    end
    task automatic end_of_test();
        if (n_mismatch == 0 && total_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic flag(string nm, logic e, logic g);
        total_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("Error %s expected %b seen %b", nm, e, g);
        end
    endtask
    task automatic cmp_rd(logic [15:0] e, logic [15:0] g);
        total_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("Error regRdata expected %h seen %h", e, g);
        end
    endtask
    task automatic cyc(int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task automatic wr(logic [3:0] a, logic [15:0] d);
        @(posedge sys_clk);
        {regWr, regAddr, regWdata} <= {1'b1, a, d};
        @(posedge sys_clk);
        regWr <= 1'b0;
    endtask
    task automatic rd(logic [3:0] a, logic [15:0] e);
        expQ.push_back(e);
        @(posedge sys_clk);
        {regRd, regAddr} <= {1'b1, a};
        @(posedge sys_clk);
        regRd <= 1'b0;
    endtask
    task automatic frame();
        @(posedge sys_clk);
        frameValid <= 1'b1;
        @(posedge sys_clk);
        frameValid <= 1'b0;
    endtask
    // Read data stand only in the cycle after the strobe, so look mid-cycle.
    always @(posedge sys_clk) rdLag <= regRd;
    always @(negedge sys_clk) begin
        if (rdLag) begin
            cmp_rd(expQ.pop_front(), regRdata);
        end
    end
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 5000) begin
            n_mismatch++;
            end_of_test();
        end
    end
    initial begin
        void'($urandom(2314));
        repeat (2) @(posedge sys_clk);
        reset <= 1'b0;
        rd(PBW_OFS_STAT, 16'h0000);
        rd(4'h5, 16'h0000);
        wr(PBW_OFS_PVLO, 16'h0020);
        wr(PBW_OFS_PVHI, 16'h0050);
        wr(PBW_OFS_IRQMSK, 16'h0001);
        rd(PBW_OFS_PVHI, 16'h0050);
        @(posedge sys_clk);
        {fwd, pv} <= {1'b1, 16'h0010};
        cyc(4);
        flag("boost", 1'b1, boost);
        flag("running", 1'b1, running);
        flag("irq", 1'b1, irq);
        rd(PBW_OFS_STAT, 16'h0003);
        wr(PBW_OFS_IRQST, 16'h0001);
        cyc(1);
        flag("irq", 1'b0, irq);
        @(posedge sys_clk);
        pv <= 16'h0050;
        cyc(3);
        flag("boost", 1'b1, boost);
        @(posedge sys_clk);
        pv <= 16'h0060;
        cyc(3);
        flag("boost", 1'b0, boost);
        flag("running", 1'b0, running);
        flag("irq", 1'b0, irq);
        rd(PBW_OFS_IRQST, 16'h0002);
        pv <= 16'h0021 + 16'($urandom % 47);
        cyc(3);
        flag("boost", 1'b0, boost);
        @(posedge sys_clk);
        pv <= 16'h0010;
        cyc(3);
        flag("boost", 1'b1, boost);
        @(posedge sys_clk);
        fwd <= 1'b0;
        cyc(2);
        flag("boost", 1'b0, boost);
        frame();
        wr(PBW_OFS_TMO, 16'h0003);
        repeat (5) begin
            frame();
            cyc(25);
            flag("tmo", 1'b0, tmo);
        end
        for (int r = 0; r < 4; r++) begin
            wr(PBW_OFS_CTRL, 16'(r));
            tripClear <= 1'b1;
            frame();
            tripClear <= 1'b0;
            cyc(30);
            flag("tmo", 1'b0, tmo);
            cyc(25);
            flag("tmo", 1'b1, tmo);
            flag("trip", r == 0, trip);
            flag("decel", r <= 1, decel);
            flag("coast", r == 3, coast);
        end
        wr(PBW_OFS_TMO, 16'h0000);
        cyc(60);
        flag("tmo", 1'b0, tmo);
        end_of_test();
    end
endmodule
bind pbw_top pbw_checker #(.TICK_CYC(TICK_CYC)) chkU (.sys_clk(sys_clk), .reset(reset),
    .forward_run_command(forward_run_command), .pvPercent(pvPercent), .frameValid(frameValid),
    .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .pid_boost_output(pid_boost_output),
    .network_timeout_output(network_timeout_output), .tripE60(tripE60), .decelStop(decelStop),
    .coastStop(coastStop));
`default_nettype wire
